//--- hw/laeu_pkg.sv
// Contract
// RULE1 - Non-skip logic and arithmetic finish in one cycle
// RULE2 - Taken skip adds one cycle, next instruction dropped
// RULE3 - AND/OR/XOR accumulator with operand, only zero flag
// RULE4 - Complement operand into register or accumulator, zero flag
// RULE5 - Add accumulator and operand, update carry, spill, zero
// RULE6 - Add carry, accumulator, operand; update carry, spill, zero
// RULE7 - Compare operand minus accumulator, flags only, no write
// RULE8 - Compare-skip on equal or unequal, flags untouched
// RULE9 - Increment or decrement operand, only zero flag
// RULE10 - Decrement then skip on zero/nonzero, flags untouched
// RULE11 - Increment then skip on zero/nonzero, flags untouched
// RULE12 - Signed multiply, high byte to product-high, low to accumulator
// RULE13 - Unsigned multiply, high to product-high, low to accumulator
// RULE14 - Rotate through carry, only carry updated
// RULE15 - Subtract accumulator from operand, update carry, spill, zero
// RULE16 - Operand minus inverted carry minus accumulator, all three flags
// RULE17 - Nine-bit address low, destination bit just above
// RULE18 - Literal in low byte, operation in upper byte
package laeu_pkg;

  // ******************************************************************
  // Widths and field positions
  // ******************************************************************
  localparam int DATA_W    = 8;
  localparam int INSTR_W   = 16;
  localparam int ADDR_W    = 9;
  localparam int NIB_W     = 4;
  localparam int DEST_BIT  = 9;
  localparam int GRP_LSB   = 10;
  localparam int LGRP_LSB  = 8;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] PRODH_RST = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;

  // ******************************************************************
  // Register-operand groups, instruction bits 15:10
  // ******************************************************************
  localparam logic [5:0] G_CMP    = 6'h01;
  localparam logic [5:0] G_SUB    = 6'h02;
  localparam logic [5:0] G_DEC    = 6'h03;
  localparam logic [5:0] G_OR     = 6'h04;
  localparam logic [5:0] G_AND    = 6'h05;
  localparam logic [5:0] G_XOR    = 6'h06;
  localparam logic [5:0] G_ADD    = 6'h07;
  localparam logic [5:0] G_NOT    = 6'h09;
  localparam logic [5:0] G_INC    = 6'h0A;
  localparam logic [5:0] G_DECSZ  = 6'h0B;
  localparam logic [5:0] G_RR     = 6'h0C;
  localparam logic [5:0] G_RL     = 6'h0D;
  localparam logic [5:0] G_INCSZ  = 6'h0F;
  localparam logic [5:0] G_CSX    = 6'h10;
  localparam logic [5:0] G_SUBC   = 6'h12;
  localparam logic [5:0] G_DECSNZ = 6'h13;
  localparam logic [5:0] G_MULU   = 6'h14;
  localparam logic [5:0] G_MULS   = 6'h15;
  localparam logic [5:0] G_INCSNZ = 6'h16;
  localparam logic [5:0] G_ADDC   = 6'h17;

  // ******************************************************************
  // Literal-operand groups, instruction bits 15:8
  // ******************************************************************
  localparam logic [7:0] L_MULU = 8'h72;
  localparam logic [7:0] L_MULS = 8'h73;
  localparam logic [7:0] L_CSNE = 8'h76;
  localparam logic [7:0] L_CSE  = 8'h77;
  localparam logic [7:0] L_CMP  = 8'h79;
  localparam logic [7:0] L_SUB  = 8'h7A;
  localparam logic [7:0] L_ADD  = 8'h7B;
  localparam logic [7:0] L_OR   = 8'h7D;
  localparam logic [7:0] L_AND  = 8'h7E;
  localparam logic [7:0] L_XOR  = 8'h7F;

  // ******************************************************************
  // Sequencer states
  // ******************************************************************
  typedef enum logic [1:0] {
    LAEU_EXEC = 2'h1,
    LAEU_SKIP = 2'h2
  } laeu_state_t;

endpackage : laeu_pkg

//--- hw/laeu_top.sv
`timescale 1ns/1ps
module laeu_top (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          instr_valid,
  input  wire logic [laeu_pkg::INSTR_W-1:0]  instr_word,
  input  wire logic [laeu_pkg::DATA_W-1:0]   file_register_operand,
  output logic                               instr_retired,
  output logic                               skip_slot,
  output logic                               fr_wr_en,
  output logic      [laeu_pkg::ADDR_W-1:0]   fr_wr_addr,
  output logic      [laeu_pkg::DATA_W-1:0]   fr_wr_data,
  output logic      [laeu_pkg::DATA_W-1:0]   accumulator,
  output logic      [laeu_pkg::DATA_W-1:0]   product_high_byte,
  output logic                               carry_flag,
  output logic                               nibble_spill_flag,
  output logic                               zero_flag
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  laeu_pkg::laeu_state_t                 state;
  laeu_pkg::laeu_state_t                 next_state;
  logic [5:0]                            reg_grp;
  logic [7:0]                            lit_grp;
  logic [laeu_pkg::DATA_W-1:0]           immediate_byte;
  logic                                  dest_fr;
  logic                                  use_lit;
  logic                                  op_and;
  logic                                  op_or;
  logic                                  op_xor;
  logic                                  op_not;
  logic                                  op_add;
  logic                                  op_addc;
  logic                                  op_sub;
  logic                                  op_subc;
  logic                                  op_cmp;
  logic                                  op_cse;
  logic                                  op_csne;
  logic                                  op_inc;
  logic                                  op_dec;
  logic                                  op_incsz;
  logic                                  op_incsnz;
  logic                                  op_decsz;
  logic                                  op_decsnz;
  logic                                  op_mulu;
  logic                                  op_muls;
  logic                                  op_rl;
  logic                                  op_rr;
  logic                                  fire;
  logic [laeu_pkg::DATA_W-1:0]           opnd;
  logic [laeu_pkg::DATA_W-1:0]           add_a;
  logic [laeu_pkg::DATA_W-1:0]           add_b;
  logic                                  add_cin;
  logic [laeu_pkg::DATA_W:0]             sum9;
  logic [laeu_pkg::NIB_W:0]              nib5;
  logic [laeu_pkg::DATA_W-1:0]           sum8;
  logic [2*laeu_pkg::DATA_W-1:0]         prod_u;
  logic signed [2*laeu_pkg::DATA_W-1:0]  prod_s;
  logic [laeu_pkg::DATA_W-1:0]           result;
  logic                                  rot_carry;
  logic                                  has_result;
  logic                                  is_mul;
  logic                                  upd_z;
  logic                                  upd_cdc;
  logic                                  upd_rot;
  logic                                  take_skip;
  logic                                  next_fr_wr_en;
  logic                                  next_acc_wr;

  // ******************************************************************
  // Opcode fields
  // ******************************************************************
  assign reg_grp        = instr_word[laeu_pkg::INSTR_W-1:laeu_pkg::GRP_LSB];   // [RULE17]
  assign dest_fr        = instr_word[laeu_pkg::DEST_BIT];                      // [RULE17]
  assign lit_grp        = instr_word[laeu_pkg::INSTR_W-1:laeu_pkg::LGRP_LSB];  // [RULE18]
  assign immediate_byte = instr_word[laeu_pkg::DATA_W-1:0];                    // [RULE18]

  // An instruction presented in the skip slot is dropped, never executed
  assign fire = instr_valid && (state == laeu_pkg::LAEU_EXEC);                 // [RULE2]

  // ******************************************************************
  // Decode
  // ******************************************************************
  always_comb begin
    use_lit   = 1'b1;
    op_and    = 1'b0;
    op_or     = 1'b0;
    op_xor    = 1'b0;
    op_not    = 1'b0;
    op_add    = 1'b0;
    op_addc   = 1'b0;
    op_sub    = 1'b0;
    op_subc   = 1'b0;
    op_cmp    = 1'b0;
    op_cse    = 1'b0;
    op_csne   = 1'b0;
    op_inc    = 1'b0;
    op_dec    = 1'b0;
    op_incsz  = 1'b0;
    op_incsnz = 1'b0;
    op_decsz  = 1'b0;
    op_decsnz = 1'b0;
    op_mulu   = 1'b0;
    op_muls   = 1'b0;
    op_rl     = 1'b0;
    op_rr     = 1'b0;
    // Literal forms share the 0111 prefix with no register group
    case (lit_grp)                                                             // [RULE18]
      laeu_pkg::L_MULU: op_mulu = 1'b1;
      laeu_pkg::L_MULS: op_muls = 1'b1;
      laeu_pkg::L_CSNE: op_csne = 1'b1;
      laeu_pkg::L_CSE:  op_cse  = 1'b1;
      laeu_pkg::L_CMP:  op_cmp  = 1'b1;
      laeu_pkg::L_SUB:  op_sub  = 1'b1;
      laeu_pkg::L_ADD:  op_add  = 1'b1;
      laeu_pkg::L_OR:   op_or   = 1'b1;
      laeu_pkg::L_AND:  op_and  = 1'b1;
      laeu_pkg::L_XOR:  op_xor  = 1'b1;
      default: begin
        use_lit = 1'b0;
        case (reg_grp)                                                         // [RULE17]
          laeu_pkg::G_CMP:    op_cmp    = !dest_fr;
          laeu_pkg::G_SUB:    op_sub    = 1'b1;
          laeu_pkg::G_DEC:    op_dec    = 1'b1;
          laeu_pkg::G_OR:     op_or     = 1'b1;
          laeu_pkg::G_AND:    op_and    = 1'b1;
          laeu_pkg::G_XOR:    op_xor    = 1'b1;
          laeu_pkg::G_ADD:    op_add    = 1'b1;
          laeu_pkg::G_NOT:    op_not    = 1'b1;
          laeu_pkg::G_INC:    op_inc    = 1'b1;
          laeu_pkg::G_DECSZ:  op_decsz  = 1'b1;
          laeu_pkg::G_RR:     op_rr     = 1'b1;
          laeu_pkg::G_RL:     op_rl     = 1'b1;
          laeu_pkg::G_INCSZ:  op_incsz  = 1'b1;
          laeu_pkg::G_CSX: begin
            // Destination bit picks the equal variant here
            op_cse  = dest_fr;
            op_csne = !dest_fr;
          end
          laeu_pkg::G_SUBC:   op_subc   = 1'b1;
          laeu_pkg::G_DECSNZ: op_decsnz = 1'b1;
          laeu_pkg::G_MULU:   op_mulu   = 1'b1;
          laeu_pkg::G_MULS:   op_muls   = 1'b1;
          laeu_pkg::G_INCSNZ: op_incsnz = 1'b1;
          laeu_pkg::G_ADDC:   op_addc   = 1'b1;
          default: ;
        endcase
      end
    endcase
  end

  assign opnd = use_lit ? immediate_byte : file_register_operand;

  // ******************************************************************
  // Shared adder
  // ******************************************************************
  // One adder serves add, subtract, compare and count; subtraction is
  // operand plus inverted accumulator, so carry out means no borrow.
  always_comb begin
    add_a   = opnd;
    add_b   = 8'h00;
    add_cin = 1'b0;
    if (op_add || op_addc) begin
      add_a   = accumulator;                                                   // [RULE5]
      add_b   = opnd;
      add_cin = op_addc ? carry_flag : 1'b0;                                   // [RULE6]
    end else if (op_sub || op_cmp || op_cse || op_csne) begin
      add_b   = ~accumulator;                                                  // [RULE15] [RULE7] [RULE8]
      add_cin = 1'b1;
    end else if (op_subc) begin
      add_b   = ~accumulator;                                                  // [RULE16]
      add_cin = carry_flag;
    end else if (op_inc || op_incsz || op_incsnz) begin
      add_cin = 1'b1;                                                          // [RULE9] [RULE11]
    end else if (op_dec || op_decsz || op_decsnz) begin
      add_b   = 8'hFF;                                                         // [RULE9] [RULE10]
    end
  end

  assign sum9 = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
  assign nib5 = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  assign sum8 = sum9[laeu_pkg::DATA_W-1:0];

  // ******************************************************************
  // Multiplier
  // ******************************************************************
  assign prod_u = {8'h00, accumulator} * {8'h00, opnd};                        // [RULE13]
  assign prod_s = $signed({{8{accumulator[7]}}, accumulator})
                * $signed({{8{opnd[7]}}, opnd});                               // [RULE12]
  assign is_mul = op_mulu || op_muls;

  // ******************************************************************
  // Result select
  // ******************************************************************
  always_comb begin
    result     = sum8;
    rot_carry  = carry_flag;
    has_result = 1'b1;
    if (op_and) begin
      result = accumulator & opnd;                                             // [RULE3]
    end else if (op_or) begin
      result = accumulator | opnd;                                             // [RULE3]
    end else if (op_xor) begin
      result = accumulator ^ opnd;                                             // [RULE3]
    end else if (op_not) begin
      result = ~opnd;                                                          // [RULE4]
    end else if (op_rl) begin
      result    = {opnd[6:0], carry_flag};                                     // [RULE14]
      rot_carry = opnd[7];
    end else if (op_rr) begin
      result    = {carry_flag, opnd[7:1]};                                     // [RULE14]
      rot_carry = opnd[0];
    end else if (op_cmp || op_cse || op_csne || is_mul) begin
      has_result = 1'b0;                                                       // [RULE7]
    end else if (!(op_add || op_addc || op_sub || op_subc || op_inc || op_dec
                   || op_incsz || op_incsnz || op_decsz || op_decsnz)) begin
      has_result = 1'b0;
    end
  end

  // ******************************************************************
  // Flag and skip selection
  // ******************************************************************
  // Skip variants leave every flag alone
  assign upd_z   = op_and || op_or || op_xor || op_not || op_inc || op_dec     // [RULE3] [RULE4] [RULE9]
                || op_add || op_addc || op_sub || op_subc || op_cmp;           // [RULE5] [RULE7]
  assign upd_cdc = op_add || op_addc || op_sub || op_subc || op_cmp;           // [RULE6] [RULE15] [RULE16]
  assign upd_rot = op_rl || op_rr;                                             // [RULE14]

  always_comb begin
    take_skip = 1'b0;
    if (op_cse || op_incsz || op_decsz) begin
      take_skip = (sum8 == 8'h00);                                             // [RULE8] [RULE10] [RULE11]
    end else if (op_csne || op_incsnz || op_decsnz) begin
      take_skip = (sum8 != 8'h00);                                             // [RULE8] [RULE10] [RULE11]
    end
  end

  // Literal forms other than compares always land in the accumulator
  assign next_fr_wr_en = fire && has_result && dest_fr && !use_lit;            // [RULE17]
  assign next_acc_wr   = fire && has_result && !(dest_fr && !use_lit);

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      laeu_pkg::LAEU_EXEC: begin
        if (fire && take_skip) begin
          next_state = laeu_pkg::LAEU_SKIP;                                    // [RULE2]
        end
      end
      laeu_pkg::LAEU_SKIP: begin
        // Exactly one slot is spent, whatever arrives in it
        next_state = laeu_pkg::LAEU_EXEC;                                      // [RULE2]
      end
      default: next_state = laeu_pkg::LAEU_EXEC;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= laeu_pkg::LAEU_EXEC;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      skip_slot <= 1'b0;
    end else begin
      skip_slot <= fire && take_skip;                                          // [RULE2]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      instr_retired <= 1'b0;
    end else begin
      instr_retired <= fire;                                                   // [RULE1]
    end
  end

  // ******************************************************************
  // Accumulator and product-high
  // ******************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      accumulator <= laeu_pkg::ACC_RST;
    end else if (fire && op_mulu) begin
      accumulator <= prod_u[7:0];                                              // [RULE13]
    end else if (fire && op_muls) begin
      accumulator <= prod_s[7:0];                                              // [RULE12]
    end else if (next_acc_wr) begin
      accumulator <= result;                                                   // [RULE1]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      product_high_byte <= laeu_pkg::PRODH_RST;
    end else if (fire && op_mulu) begin
      product_high_byte <= prod_u[15:8];                                       // [RULE13]
    end else if (fire && op_muls) begin
      product_high_byte <= prod_s[15:8];                                       // [RULE12]
    end
  end

  // ******************************************************************
  // File register write port
  // ******************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fr_wr_en   <= 1'b0;
      fr_wr_addr <= '0;
      fr_wr_data <= 8'h00;
    end else begin
      fr_wr_en <= next_fr_wr_en;                                               // [RULE1]
      if (next_fr_wr_en) begin
        fr_wr_addr <= instr_word[laeu_pkg::ADDR_W-1:0];                        // [RULE17]
        fr_wr_data <= result;
      end
    end
  end

  // ******************************************************************
  // Status flags
  // ******************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      zero_flag <= laeu_pkg::FLAG_RST;
    end else if (fire && upd_z) begin
      zero_flag <= (sum8 == 8'h00) && !(op_and || op_or || op_xor || op_not)
                || (result == 8'h00) && (op_and || op_or || op_xor || op_not);  // [RULE3] [RULE9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carry_flag <= laeu_pkg::FLAG_RST;
    end else if (fire && upd_cdc) begin
      carry_flag <= sum9[laeu_pkg::DATA_W];                                    // [RULE5] [RULE7]
    end else if (fire && upd_rot) begin
      carry_flag <= rot_carry;                                                 // [RULE14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nibble_spill_flag <= laeu_pkg::FLAG_RST;
    end else if (fire && upd_cdc) begin
      nibble_spill_flag <= nib5[laeu_pkg::NIB_W];                              // [RULE5] [RULE15]
    end
  end

endmodule : laeu_top

//--- verification/laeu_top_props.sv
`timescale 1ns/1ps
module laeu_top_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  file_register_operand,
  input wire logic        instr_retired,
  input wire logic        skip_slot,
  input wire logic        fr_wr_en,
  input wire logic [8:0]  fr_wr_addr,
  input wire logic [7:0]  fr_wr_data,
  input wire logic [7:0]  accumulator,
  input wire logic [7:0]  product_high_byte,
  input wire logic        carry_flag,
  input wire logic        nibble_spill_flag,
  input wire logic        zero_flag
);
  // ******
  // Properties
  // ******
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    instr_valid && !skip_slot;
  endsequence
  // The annulled slot must also swallow the write strobe, not only the retire pulse
  sequence s_annul;
    instr_retired ##1 (!skip_slot && !instr_retired && !fr_wr_en);
  endsequence
  property p_retire; s_take |=> instr_retired; endproperty
  a_retire: assert property (p_retire) else $error("taken instruction not retired");
  property p_drop; !(instr_valid && !skip_slot) |=> !instr_retired; endproperty
  a_drop: assert property (p_drop) else $error("dropped instruction retired");
  property p_skip; skip_slot |-> s_annul; endproperty
  a_skip: assert property (p_skip) else $error("skip slot malformed");
  property p_skip_flags;
    skip_slot |-> $stable(carry_flag) && $stable(nibble_spill_flag) && $stable(zero_flag);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");
  property p_and_lit;
    s_take ##0 (instr_word[15:8] == laeu_pkg::L_AND) |=> accumulator == ($past(accumulator) & $past(instr_word[7:0]))
      && zero_flag == (accumulator == 8'h00) && $stable(carry_flag);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");
  property p_mulu_lit;
    s_take ##0 (instr_word[15:8] == laeu_pkg::L_MULU) |=> $stable(zero_flag)
      && {product_high_byte, accumulator} == {8'h00, $past(accumulator)} * {8'h00, $past(instr_word[7:0])};
  endproperty
  a_mulu_lit: assert property (p_mulu_lit) else $error("unsigned multiply wrong");
  property p_cmp_lit;
    s_take ##0 (instr_word[15:8] == laeu_pkg::L_CMP) |=> $stable(accumulator) && !fr_wr_en
      && carry_flag == ($past(instr_word[7:0]) >= $past(accumulator))
      && zero_flag == ($past(instr_word[7:0]) == $past(accumulator));
  endproperty
  a_cmp_lit: assert property (p_cmp_lit) else $error("compare literal wrong");
  property p_wr_addr; fr_wr_en |-> fr_wr_addr == $past(instr_word[8:0]) && $past(instr_word[9]); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");
  property p_acc_dest; s_take ##0 (instr_word[15:12] != 4'h7 && !instr_word[9]) |=> !fr_wr_en; endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("accumulator form wrote register");
  property p_lit_dest; s_take ##0 (instr_word[15:12] == 4'h7) |=> !fr_wr_en; endproperty
  a_lit_dest: assert property (p_lit_dest) else $error("literal form wrote register");
endmodule : laeu_top_props

bind laeu_top laeu_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .file_register_operand(file_register_operand), .instr_retired(instr_retired),
  .skip_slot(skip_slot), .fr_wr_en(fr_wr_en), .fr_wr_addr(fr_wr_addr), .fr_wr_data(fr_wr_data),
  .accumulator(accumulator), .product_high_byte(product_high_byte), .carry_flag(carry_flag),
  .nibble_spill_flag(nibble_spill_flag), .zero_flag(zero_flag));

//--- verification/laeu_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module laeu_top_test;
  logic        clk_sys, rst_n, instr_valid, instr_retired, skip_slot, fr_wr_en;
  logic        carry_flag, nibble_spill_flag, zero_flag;
  logic [15:0] instr_word;
  logic [8:0]  fr_wr_addr;
  logic [7:0]  operand, fr_wr_data, accumulator, product_high_byte;
  int          bad_count = 0;
  int          checks_done = 0;
  laeu_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_register_operand(operand), .instr_retired(instr_retired), .skip_slot(skip_slot),
    .fr_wr_en(fr_wr_en), .fr_wr_addr(fr_wr_addr), .fr_wr_data(fr_wr_data), .accumulator(accumulator),
    .product_high_byte(product_high_byte), .carry_flag(carry_flag), .nibble_spill_flag(nibble_spill_flag),
    .zero_flag(zero_flag));
  // ******
  // Drivers
  // ******
  // Inputs stay driven on return so the next call assigns them once per time step
  task automatic run(input logic [15:0] w, input logic [7:0] op);
    instr_valid = 1'b1;
    instr_word = w;
    operand = op;
    @(negedge clk_sys);
  endtask : run
  task automatic set_w(input logic [7:0] k);
    run({laeu_pkg::G_AND, 1'b0, 9'h0}, 8'h00);
    run({laeu_pkg::L_OR, k}, 8'h00);
  endtask : set_w
  task tally_and_finish;
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ******
  // Scenarios
  // ******
  task automatic t_logic;
    set_w(8'h5A);
    run({laeu_pkg::L_AND, 8'h0F}, 8'h00);
    `CHK({accumulator, zero_flag}, {8'h0A, 1'b0})
    run({laeu_pkg::L_XOR, 8'h0A}, 8'h00);
    `CHK({accumulator, zero_flag}, {8'h00, 1'b1})
    run({laeu_pkg::G_OR, 1'b1, 9'h023}, 8'hA5);
    `CHK({fr_wr_en, fr_wr_addr, fr_wr_data, accumulator, zero_flag}, {1'b1, 9'h023, 8'hA5, 8'h00, 1'b0})
    run({laeu_pkg::G_NOT, 1'b0, 9'h023}, 8'hFF);
    `CHK({fr_wr_en, accumulator, zero_flag}, {1'b0, 8'h00, 1'b1})
    run({laeu_pkg::G_NOT, 1'b1, 9'h011}, 8'h0F);
    `CHK({fr_wr_en, fr_wr_data, accumulator, zero_flag}, {1'b1, 8'hF0, 8'h00, 1'b0})
  endtask : t_logic
  task automatic t_arith;
    set_w(8'h01);
    run({laeu_pkg::G_ADD, 1'b1, 9'h005}, 8'h0F);
    `CHK({instr_retired, fr_wr_en, fr_wr_data, carry_flag, nibble_spill_flag, zero_flag}, 13'h1882)
    run({laeu_pkg::L_ADD, 8'hFF}, 8'h00);
    `CHK({accumulator, carry_flag, nibble_spill_flag, zero_flag}, {8'h00, 3'h7})
    run({laeu_pkg::G_ADDC, 1'b0, 9'h005}, 8'h10);
    `CHK({accumulator, carry_flag, nibble_spill_flag, zero_flag}, {8'h11, 3'h0})
    run({laeu_pkg::L_SUB, 8'h11}, 8'h00);
    `CHK({accumulator, carry_flag, nibble_spill_flag, zero_flag}, {8'h00, 3'h7})
    run({laeu_pkg::G_SUBC, 1'b0, 9'h005}, 8'h05);
    `CHK({accumulator, carry_flag, nibble_spill_flag, zero_flag}, {8'h05, 3'h6})
    run({laeu_pkg::L_CMP, 8'h03}, 8'h00);
    `CHK({fr_wr_en, accumulator, carry_flag, nibble_spill_flag, zero_flag}, {1'b0, 8'h05, 3'h0})
    run({laeu_pkg::G_SUBC, 1'b1, 9'h007}, 8'h05);
    `CHK({fr_wr_data, accumulator, carry_flag, nibble_spill_flag, zero_flag}, {16'hFF05, 3'h0})
  endtask : t_arith
  task automatic t_skip;
    logic [15:0] words [8] = '{16'h3E05, 16'h2E05, 16'h5A05, 16'h4E05, 16'h4205, 16'h4005, 16'h7700, 16'h7601};
    logic [7:0]  ops [8] = '{8'hFF, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  wdat [4] = '{8'h00, 8'h00, 8'h02, 8'h00};
    logic [0:7]  skp = 8'hEB;
    logic [0:7]  wen = 8'hF0;
    logic [2:0]  flags;
    set_w(8'h00);
    for (int i = 0; i < 8; i++) begin
      flags = {carry_flag, nibble_spill_flag, zero_flag};
      run(words[i], ops[i]);
      `CHK({skip_slot, instr_retired, fr_wr_en, carry_flag, nibble_spill_flag, zero_flag}, {skp[i], 1'b1, wen[i], flags})
      if (wen[i]) `CHK(fr_wr_data, wdat[i])
      run({laeu_pkg::G_XOR, 1'b1, 9'h030}, 8'h00);
      `CHK({instr_retired, fr_wr_en, skip_slot}, {~skp[i], ~skp[i], 1'b0})
    end
  endtask : t_skip
  task automatic t_mul;
    logic [2:0] flags;
    set_w(8'h02);
    flags = {carry_flag, nibble_spill_flag, zero_flag};
    run({laeu_pkg::L_MULS, 8'hFF}, 8'h00);
    `CHK({product_high_byte, accumulator}, 16'hFFFE)
    run({laeu_pkg::L_MULU, 8'hFF}, 8'h00);
    `CHK({product_high_byte, accumulator}, 16'hFD02)
    run({laeu_pkg::G_MULU, 1'b0, 9'h005}, 8'h81);
    `CHK({product_high_byte, accumulator}, 16'h0102)
    run({laeu_pkg::G_MULS, 1'b0, 9'h005}, 8'h80);
    `CHK({fr_wr_en, product_high_byte, accumulator, carry_flag, nibble_spill_flag, zero_flag}, {17'h0FF00, flags})
  endtask : t_mul
  task automatic t_rot_incdec;
    set_w(8'h01);
    run({laeu_pkg::L_ADD, 8'hFF}, 8'h00);
    run({laeu_pkg::G_RL, 1'b0, 9'h005}, 8'h80);
    `CHK({accumulator, carry_flag, zero_flag}, {8'h01, 2'h3})
    run({laeu_pkg::G_RR, 1'b1, 9'h005}, 8'h02);
    `CHK({fr_wr_en, fr_wr_data, carry_flag, accumulator}, {1'b1, 8'h81, 1'b0, 8'h01})
    run({laeu_pkg::G_INC, 1'b0, 9'h005}, 8'hFF);
    `CHK({accumulator, zero_flag}, {8'h00, 1'b1})
    run({laeu_pkg::G_DEC, 1'b1, 9'h005}, 8'h05);
    `CHK({fr_wr_en, fr_wr_data, accumulator, zero_flag}, {1'b1, 16'h0400, 1'b0})
  endtask : t_rot_incdec
  // ******
  // Sequence
  // ******
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    operand = 8'h00;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_logic();
    t_arith();
    t_skip();
    t_mul();
    t_rot_incdec();
    tally_and_finish();
  end
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
endmodule : laeu_top_test
